// ### hw/fbo_host.sv
// Host-side controller that drives a 128K x 8 parallel flash over its pins.
// Assumes pin inputs are synchronous to mclk and the high-voltage driver on
// address line 9 is switched by the board from the hv output.
`timescale 1ns/10ps
`include "fbo_params.svh"

module fbo_host #(
    parameter int ACC_CYC = `FBO_ACC_CYC,
    parameter int WP_CYC  = `FBO_WP_CYC
) (
    input  wire logic                     mclk,
    input  wire logic                     arst_n,
    input  wire fbo_pkg::fbo_req_s        req,
    input  wire logic                     req_valid,
    output logic                          req_ready,
    output fbo_pkg::fbo_rsp_s             rsp,
    output logic [`FBO_ADDR_W-1:0]        byte_address_lines,
    output logic                          ce_n,
    output logic                          oe_n,
    output logic                          we_n,
    output logic                          a9_hv,
    input  wire logic [`FBO_DATA_W-1:0]   byte_data_pins_i,
    output logic [`FBO_DATA_W-1:0]        byte_data_pins_o,
    output logic                          byte_data_pins_oe_n
);
    import fbo_pkg::*;

    typedef enum logic [2:0] {
        FBO_ST_IDLE  = 3'h0,
        FBO_ST_SETUP = 3'h1,
        FBO_ST_RD    = 3'h2,
        FBO_ST_WP    = 3'h3,
        FBO_ST_WHOLD = 3'h4,
        FBO_ST_RECOV = 3'h5
    } fbo_state_e;

    localparam logic [7:0] ACC_LAST = 8'(ACC_CYC - 1);
    localparam logic [7:0] WP_LAST  = 8'(WP_CYC - 1);

    // Sector index from the two highest address bits
    function automatic logic [1:0] fbo_sector(input logic [`FBO_ADDR_W-1:0] a);
        fbo_sector = a[`FBO_ADDR_W-1:`FBO_SECT_LSB];
    endfunction : fbo_sector

    // Reset release through two flops; first flop feeds only the second
    logic rst_meta_q;
    logic rst_n_q;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    fbo_state_e              state_q;
    logic [7:0]              cnt_q;
    fbo_op_e                 op_q;

    // Request decode
    wire accept   = req_valid && req_ready;
    wire is_id    = (req.op == FBO_OP_ID);
    wire is_write = (op_q == FBO_OP_WRITE);
    wire cnt_zero = (cnt_q == 8'h00);
    // High-voltage selection needs A6 low; the other bits pass as given
    wire [`FBO_ADDR_W-1:0] id_addr = req.addr & ~(`FBO_ADDR_W'(1) << `FBO_A6_BIT);
    wire [`FBO_ADDR_W-1:0] out_addr = is_id ? id_addr : req.addr;
    wire prot_sel = (op_q == FBO_OP_ID)
                    && (byte_address_lines[1:0] == `FBO_SEL_PROT);
    wire prot_hit = prot_sel && (byte_data_pins_i == `FBO_PROT_CODE);

    // Bus-cycle sequencer; every pin comes straight from a flop
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q             <= FBO_ST_IDLE;
            cnt_q               <= 8'h00;
            op_q                <= FBO_OP_READ;
            req_ready           <= 1'b0;
            rsp                 <= '0;
            byte_address_lines  <= '0;
            ce_n                <= 1'b1;
            oe_n                <= 1'b1;
            we_n                <= 1'b1;
            a9_hv               <= 1'b0;
            byte_data_pins_o    <= '0;
            byte_data_pins_oe_n <= 1'b1;
        end else begin
            rsp.done <= 1'b0;
            case (state_q)
                FBO_ST_IDLE: begin
                    req_ready <= 1'b1;
                    if (accept) begin
                        req_ready          <= 1'b0;
                        op_q               <= req.op;
                        byte_address_lines <= out_addr;
                        byte_data_pins_o   <= req.data;
                        a9_hv              <= is_id;
                        ce_n               <= 1'b0;
                        state_q            <= FBO_ST_SETUP;
                    end
                end
                FBO_ST_SETUP: begin
                    // Address is stable a cycle before strobe or gate falls
                    if (is_write) begin
                        byte_data_pins_oe_n <= 1'b0;
                        we_n                <= 1'b0;
                        cnt_q               <= WP_LAST;
                        state_q             <= FBO_ST_WP;
                    end else begin
                        oe_n    <= 1'b0;
                        cnt_q   <= ACC_LAST;
                        state_q <= FBO_ST_RD;
                    end
                end
                FBO_ST_RD: begin
                    if (cnt_zero) begin
                        rsp.rdata <= byte_data_pins_i;
                        rsp.prot  <= prot_hit;
                        rsp.sector <= fbo_sector(byte_address_lines);
                        oe_n      <= 1'b1;
                        ce_n      <= 1'b1;
                        state_q   <= FBO_ST_RECOV;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                FBO_ST_WP: begin
                    if (cnt_zero) begin
                        we_n    <= 1'b1;
                        state_q <= FBO_ST_WHOLD;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                FBO_ST_WHOLD: begin
                    // Data held one cycle past the strobe rise
                    byte_data_pins_oe_n <= 1'b1;
                    ce_n                <= 1'b1;
                    rsp.sector          <= fbo_sector(byte_address_lines);
                    rsp.prot            <= 1'b0;
                    state_q             <= FBO_ST_RECOV;
                end
                FBO_ST_RECOV: begin
                    a9_hv     <= 1'b0;
                    rsp.done  <= 1'b1;
                    req_ready <= 1'b1;
                    state_q   <= FBO_ST_IDLE;
                end
                default: begin
                    state_q <= FBO_ST_IDLE;
                end
            endcase
        end
    end

    // Helper: length of the current gate-low window
    logic [7:0] oe_len_q;
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            oe_len_q <= 8'h00;
        end else begin
            oe_len_q <= oe_n ? 8'h00 : oe_len_q + 8'h01;
        end
    end

    // Protocol checks on the pins and on the response that this controller drives
    default clocking fbo_cb @(posedge mclk); endclocking
    default disable iff (!rst_n_q);

    a_read_we_high: assert property (!oe_n |-> we_n)
        else $error("write strobe low during read");
    a_read_select: assert property (!oe_n |-> !ce_n)
        else $error("gate low without chip select");
    a_write_levels: assert property (!we_n |-> (!ce_n && oe_n))
        else $error("write strobe without select or with gate low");
    a_no_drive_gate: assert property (!byte_data_pins_oe_n |-> oe_n)
        else $error("host drives data while gate low");
    a_read_length: assert property ($rose(oe_n) |-> oe_len_q == 8'(ACC_CYC))
        else $error("read window length wrong");
    a_hv_a6_low: assert property (a9_hv |-> !byte_address_lines[`FBO_A6_BIT])
        else $error("A6 high while high voltage on A9");
    a_write_data_held: assert property ($rose(we_n) |-> !byte_data_pins_oe_n
                                        && $stable(byte_data_pins_o))
        else $error("write data not held past strobe rise");
    a_done_after: assert property (accept |-> ##[3:40] rsp.done)
        else $error("request not answered");
    a_idle_standby: assert property ((state_q == FBO_ST_IDLE) |-> ce_n && oe_n && we_n)
        else $error("pins not idle between cycles");

    // Main scenario coverage
    c_read: cover property (accept && req.op == FBO_OP_READ ##[1:40] rsp.done);
    c_id: cover property (accept && req.op == FBO_OP_ID ##[1:40] rsp.done);
    c_write: cover property (accept && req.op == FBO_OP_WRITE ##[1:40] rsp.done);
    c_prot: cover property (rsp.done && rsp.prot);

endmodule : fbo_host

// ### hw/fbo_params.svh
// Constants for the parallel flash bus-operation host controller.
// Assumes a single 25 MHz clock; all times below are in nanoseconds.
`ifndef FBO_PARAMS_SVH
`define FBO_PARAMS_SVH

`define FBO_CLK_NS      40
`define FBO_T_ACC_NS    100
`define FBO_T_WP_NS     50
`define FBO_ACC_CYC     ((`FBO_T_ACC_NS + `FBO_CLK_NS - 1) / `FBO_CLK_NS)
`define FBO_WP_CYC      ((`FBO_T_WP_NS + `FBO_CLK_NS - 1) / `FBO_CLK_NS)

`define FBO_ADDR_W      17
`define FBO_DATA_W      8
`define FBO_SECT_LSB    15
`define FBO_A6_BIT      6
`define FBO_PROT_CODE   8'h01
`define FBO_SEL_PROT    2'h2

`endif

// ### hw/fbo_pkg.sv
// Types shared by the flash host controller and its users.
// Widths come from the constants header.
`include "fbo_params.svh"

package fbo_pkg;

    typedef enum logic [1:0] {
        FBO_OP_READ  = 2'h0,
        FBO_OP_WRITE = 2'h1,
        FBO_OP_ID    = 2'h2
    } fbo_op_e;

    typedef struct packed {
        fbo_op_e                   op;
        logic [`FBO_ADDR_W-1:0]    addr;
        logic [`FBO_DATA_W-1:0]    data;
    } fbo_req_s;

    typedef struct packed {
        logic                      done;
        logic [`FBO_DATA_W-1:0]    rdata;
        logic [1:0]                sector;
        logic                      prot;
    } fbo_rsp_s;

endpackage : fbo_pkg

// ### tb/fbo_flash_model.sv
// Behavioural flash device model for the host controller bench.
// Assumes pins come from one clocked host; no timing checks are made.
`timescale 1ns/10ps
module fbo_flash_model #(
    parameter logic [7:0] MFR_CODE  = 8'h5a, // Arbitrary value
    parameter logic [7:0] DEV_CODE  = 8'hc3, // Arbitrary value
    parameter logic [7:0] CONT_CODE = 8'h3c, // Arbitrary value
    parameter logic [3:0] PROT_MAP  = 4'h4
) (
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        a9_hv,
    input  wire logic [16:0] addr,
    input  wire logic [7:0]  din,
    output logic [7:0]       dout,
    output logic             drv,
    output logic [16:0]      wr_addr,
    output logic [7:0]       wr_data
);
    // Power-up lands in read-array mode, nothing erased or busy
    logic       autosel = 1'b0;
    logic       wact    = 1'b0;
    logic       tog     = 1'b0;
    logic [1:0] busy    = 2'h0;
    logic [3:0] erased  = 4'h0;
    logic [7:0] code;
    wire  [1:0] sel = addr[1:0];
    // Address on the later fall; latches sit outside the array map
    always @(negedge we_n or negedge ce_n) begin
        if (!we_n && !ce_n && oe_n) begin
            wr_addr = addr;
            wact = 1'b1;
        end
    end
    // Data on the earlier rise; unknown bytes leave the mode alone
    always @(posedge we_n or posedge ce_n) begin
        if (wact) begin
            wact = 1'b0;
            wr_data = din;
            if (din == 8'h90) autosel = 1'b1;
            if (din == 8'hf0) autosel = 1'b0;
            if (din == 8'h30) begin
                erased[wr_addr[16:15]] = 1'b1;
                busy = 2'h2;
            end
            if (din == 8'h10) begin
                erased = 4'hf;
                busy = 2'h2;
            end
        end
    end
    // Busy counts down on finished reads only, so deselect never aborts it
    always @(posedge oe_n) begin
        if (busy != 2'h0) begin
            busy = busy - 2'h1;
            tog = ~tog;
        end
    end
    // Drive only in a read; float in standby and output disable
    assign drv = !ce_n && !oe_n && we_n;
    assign code = addr[6] ? 8'h00 : sel == 2'h0 ? MFR_CODE : sel == 2'h1 ? DEV_CODE
                : sel == 2'h2 ? {7'h00, PROT_MAP[addr[16:15]]} : CONT_CODE;
    assign dout = busy != 2'h0 ? {1'b0, tog, 6'h00}
                : (a9_hv || autosel) ? code
                : erased[addr[16:15]] ? 8'hff
                : addr[7:0] ^ {6'h00, addr[16:15]};
endmodule : fbo_flash_model

// ### tb/tb.sv
// Self-checking bench for the flash host controller.
// Assumes the behavioural device model sits on the pin side.
`timescale 1ns/10ps
`include "fbo_params.svh"
module tb;
    import fbo_pkg::*;
    logic        mclk, arst_n, req_valid, req_ready, ce_n, oe_n, we_n, a9_hv;
    logic        dq_oe_n, drv;
    logic [16:0] addr, wr_addr;
    logic [7:0]  dq_o, dq_i, dout, wr_data;
    logic [7:0]  flt_q = 8'h00;
    fbo_req_s    req;
    fbo_rsp_s    rsp;
    int          err_count, cmp_count, cyc;
    localparam logic [7:0] IDS [4] = '{8'h5a, 8'hc3, 8'h01, 8'h3c};
    // Released bus shows a changing pattern, never the last value
    assign dq_i = !dq_oe_n ? dq_o : drv ? dout : flt_q;
    always @(posedge mclk) flt_q <= ~dq_i;
    fbo_host fbo_host_i (.mclk(mclk), .arst_n(arst_n), .req(req), .req_valid(req_valid),
        .req_ready(req_ready), .rsp(rsp), .byte_address_lines(addr), .ce_n(ce_n),
        .oe_n(oe_n), .we_n(we_n), .a9_hv(a9_hv), .byte_data_pins_i(dq_i),
        .byte_data_pins_o(dq_o), .byte_data_pins_oe_n(dq_oe_n));
    fbo_flash_model #(.MFR_CODE(IDS[0]), .DEV_CODE(IDS[1]), .CONT_CODE(IDS[3]),
        .PROT_MAP(4'h4)) fbo_flash_model_i (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .a9_hv(a9_hv), .addr(addr), .din(dq_i), .dout(dout), .drv(drv),
        .wr_addr(wr_addr), .wr_data(wr_data));
    function automatic logic [7:0] arr(input logic [16:0] a);
        return a[7:0] ^ {6'h00, a[16:15]};
    endfunction : arr
    task automatic summarize();
        $display("checks %0d errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit
    // One request, called and left at a falling edge
    task automatic run_op(input fbo_op_e op, input logic [16:0] a, input logic [7:0] d);
        int n;
        n = 0;
        req = '{op, a, d};
        req_valid = 1'b1;
        while (req_ready !== 1'b1 && n < 40) begin
            @(negedge mclk);
            n++;
        end
        @(negedge mclk);
        req_valid = 1'b0;
        while (rsp.done !== 1'b1 && n < 40) begin
            @(negedge mclk);
            n++;
        end
        chk_bit(n < 40, 1'b1);
    endtask : run_op
    task automatic t_array();
        logic [16:0] al [4] = '{17'h00000, 17'h07fff, 17'h08000, 17'h1ffff};
        chk({ce_n, oe_n, we_n, dq_oe_n}, 17'hf);
        foreach (al[i]) begin
            run_op(FBO_OP_READ, al[i], 8'h00);
            chk(rsp.rdata, arr(al[i]));
            chk({15'h0, rsp.sector}, {15'h0, al[i][16:15]});
        end
    endtask : t_array
    task automatic t_write();
        run_op(FBO_OP_WRITE, 17'h0aaaa, 8'h5c);
        chk(wr_addr, 17'h0aaaa);
        chk({9'h0, wr_data}, 17'h0005c);
        chk_bit(ce_n, 1'b1);
        run_op(FBO_OP_READ, 17'h0aaaa, 8'h00);
        chk(rsp.rdata, arr(17'h0aaaa));
    endtask : t_write
    task automatic t_hv();
        for (int s = 0; s < 4; s++) begin
            run_op(FBO_OP_ID, {2'h2, 13'h0044, s[1:0]}, 8'h00);
            chk(rsp.rdata, IDS[s]);
            chk_bit(rsp.prot, s == 2);
        end
        run_op(FBO_OP_ID, 17'h08002, 8'h00);
        chk(rsp.rdata, 17'h0);
        chk_bit(rsp.prot, 1'b0);
    endtask : t_hv
    task automatic t_cmd();
        run_op(FBO_OP_WRITE, 17'h05555, 8'haa);
        run_op(FBO_OP_WRITE, 17'h02aaa, 8'h55);
        run_op(FBO_OP_WRITE, 17'h05555, 8'h90);
        run_op(FBO_OP_READ, 17'h00000, 8'h00);
        chk(rsp.rdata, IDS[0]);
        run_op(FBO_OP_READ, 17'h00041, 8'h00);
        chk(rsp.rdata, 17'h0);
        run_op(FBO_OP_READ, 17'h00001, 8'h00);
        chk(rsp.rdata, IDS[1]);
        run_op(FBO_OP_WRITE, 17'h01234, 8'hf0);
        run_op(FBO_OP_READ, 17'h00001, 8'h00);
        chk(rsp.rdata, arr(17'h00001));
    endtask : t_cmd
    // Erase leaves lasting state, so this runs last
    task automatic t_erase();
        logic [7:0] st;
        run_op(FBO_OP_WRITE, 17'h08000, 8'h30);
        run_op(FBO_OP_WRITE, 17'h18000, 8'h30);
        run_op(FBO_OP_READ, 17'h00000, 8'h00);
        st = rsp.rdata;
        run_op(FBO_OP_READ, 17'h00000, 8'h00);
        chk({9'h0, st ^ rsp.rdata}, 17'h00040);
        run_op(FBO_OP_READ, 17'h08123, 8'h00);
        chk(rsp.rdata, 17'h000ff);
        run_op(FBO_OP_READ, 17'h18000, 8'h00);
        chk(rsp.rdata, 17'h000ff);
        run_op(FBO_OP_READ, 17'h10001, 8'h00);
        chk(rsp.rdata, arr(17'h10001));
        run_op(FBO_OP_WRITE, 17'h05555, 8'h10);
        run_op(FBO_OP_READ, 17'h00000, 8'h00);
        st = rsp.rdata;
        run_op(FBO_OP_READ, 17'h00000, 8'h00);
        chk({9'h0, st ^ rsp.rdata}, 17'h00040);
        run_op(FBO_OP_READ, 17'h10001, 8'h00);
        chk(rsp.rdata, 17'h000ff);
    endtask : t_erase
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // Hang guard, well above the few hundred cycles needed
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            summarize();
        end
    end
    initial begin
        {arst_n, req_valid, req} = '0;
        repeat (12) @(negedge mclk);
        arst_n = 1'b1;
        t_array();
        t_write();
        t_hv();
        t_cmd();
        t_erase();
        summarize();
    end
endmodule : tb
